// >>> src/oslog_defs.vh
// Constants for the operator status indication block.
// Assumes inclusion by bare name from the design file.
`ifndef OSLOG_DEFS_VH
`define OSLOG_DEFS_VH
`define OSLOG_CLK_MHZ 250
`define OSLOG_SLOW_MS 500
`define OSLOG_FAST_MS 125
`define OSLOG_SLOW_CYC ((`OSLOG_SLOW_MS * `OSLOG_CLK_MHZ * 1000) / 2)
`define OSLOG_FAST_CYC ((`OSLOG_FAST_MS * `OSLOG_CLK_MHZ * 1000) / 2)
`define OSLOG_ADDR_CTRL 12'h000
`define OSLOG_ADDR_STAT 12'h004
`define OSLOG_ADDR_ISTAT 12'h008
`define OSLOG_ADDR_IMASK 12'h00c
`define OSLOG_ADDR_FCODE 12'h010
`define OSLOG_ADDR_SPEED 12'h014
`define OSLOG_IMASK_RST 4'h0
`define OSLOG_LED_OFF 2'h0
`define OSLOG_LED_ON 2'h1
`define OSLOG_LED_FLASH 2'h2
`define OSLOG_LED_QUICK 2'h3
`define OSLOG_TAG_DRV 1'b1
`endif

// >>> src/oslog_top.v
// Operator panel status indication: alarm, local/remote and run LEDs, display selection.
// Assumes drive state inputs come from logic on hclk; panel key and terminal inputs
// are asynchronous and are synchronised here.
`timescale 1ns/10ps
`include "oslog_defs.vh"

// Summary of operation
// - Alarm LED steady on for a detected fault or error without flash case.
// - Alarm LED flashes on alarm, parameter setting error, or auto-tuning fault.
// - Alarm LED dark when no fault, error, alarm, parameter setting error or tuning fault.
// - Local/remote LED lit while keypad is the up/down command source.
// - Local/remote LED off while commands come from a remote source.
// - Run LED flashes normally while decelerating or commanded with zero speed.
// - Run LED flashes quickly after terminal command in local then switch to remote.
// - Run LED flashes quickly on terminal command while not in drive mode.
// - Run LED flashes quickly during emergency stop deceleration.
// - Run LED flashes quickly while safe disable shuts output off.
// - Run LED flashes quickly when stop key pressed running in remote.
// - On fault show fault code, light alarm LED; mode tags still follow drive_mode.
// - Normal operation shows speed reference with drive-mode tag.
// - Drive-mode tag only in drive mode, programming tag otherwise.
module oslog_top #(
	parameter SLOW_CYC = `OSLOG_SLOW_CYC,
	parameter FAST_CYC = `OSLOG_FAST_CYC,
	parameter CNT_W = 27
) (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	input wire drive_running,
	input wire drive_decel,
	input wire updown_cmd,
	input wire speed_ref_zero,
	input wire estop_decel,
	input wire safe_disable,
	input wire fault_active,
	input wire alarm_active,
	input wire error_active,
	input wire parameter_setting_error,
	input wire tune_fault,
	input wire drive_mode,
	input wire [15:0] speed_ref,
	input wire [15:0] external_fault_code,
	input wire stop_key_pin,
	input wire term_cmd_pin,
	output reg alarm_indicator,
	output reg local_remote_indicator,
	output reg run_indicator,
	output reg drive_mode_tag,
	output reg prog_mode_tag,
	output reg show_fault,
	output reg [15:0] display_data,
	output reg irq
);

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers.
	reg [1:0] stop_key_s_q;
	reg [1:0] term_cmd_s_q;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stop_key_s_q <= 2'h0;
			term_cmd_s_q <= 2'h0;
		end else begin
			stop_key_s_q <= {stop_key_s_q[0], stop_key_pin};
			term_cmd_s_q <= {term_cmd_s_q[0], term_cmd_pin};
		end
	end
	wire stop_key = stop_key_s_q[1];
	wire term_cmd = term_cmd_s_q[1];

	////////////////////////////////////////////////////////////////////////////////
	// Flash dividers.
	reg [CNT_W-1:0] slow_cnt_q;
	reg [CNT_W-1:0] fast_cnt_q;
	reg slow_ph_q;
	reg fast_ph_q;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			slow_cnt_q <= {CNT_W{1'b0}};
			fast_cnt_q <= {CNT_W{1'b0}};
			slow_ph_q <= 1'b0;
			fast_ph_q <= 1'b0;
		end else begin
			if (slow_cnt_q >= SLOW_CYC - 1) begin
				slow_cnt_q <= {CNT_W{1'b0}};
				slow_ph_q <= ~slow_ph_q;
			end else begin
				slow_cnt_q <= slow_cnt_q + 1'b1;
			end
			if (fast_cnt_q >= FAST_CYC - 1) begin
				fast_cnt_q <= {CNT_W{1'b0}};
				fast_ph_q <= ~fast_ph_q;
			end else begin
				fast_cnt_q <= fast_cnt_q + 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers over AHB-Lite.
	reg local_q;
	reg [3:0] imask_q;
	reg ap_wr_q;
	reg [11:0] ap_addr_q;
	reg [31:0] rd_mux;
	reg [1:0] run_mode;
	reg [1:0] alarm_mode;
	wire [3:0] istat_q;
	wire ap_take = hsel & hready & htrans[1];
	wire wr_ctrl = ap_wr_q & (ap_addr_q == `OSLOG_ADDR_CTRL);
	wire wr_istat = ap_wr_q & (ap_addr_q == `OSLOG_ADDR_ISTAT);
	wire wr_imask = ap_wr_q & (ap_addr_q == `OSLOG_ADDR_IMASK);

	// The address phase is captured here; its data phase follows one cycle later.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_wr_q <= 1'b0;
			ap_addr_q <= 12'h000;
		end else begin
			ap_wr_q <= ap_take & hwrite;
			if (ap_take) begin
				ap_addr_q <= haddr[11:0];
			end
		end
	end

	// The slave never stalls and never errors, so both answers are constant flops.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// Source can only change while stopped, as on the panel key.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			local_q <= 1'b1;
		end else if (wr_ctrl && !drive_running) begin
			local_q <= hwdata[0];
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			imask_q <= `OSLOG_IMASK_RST;
		end else if (wr_imask) begin
			imask_q <= hwdata[3:0];
		end
	end

	// Read data is chosen in the address phase so that it stands through the data phase.
	always @* begin
		rd_mux = 32'h0;
		case (haddr[11:0])
			`OSLOG_ADDR_CTRL: rd_mux = {31'h0, local_q};
			`OSLOG_ADDR_STAT: rd_mux = {27'h0, alarm_mode, run_mode, local_q};
			`OSLOG_ADDR_ISTAT: rd_mux = {28'h0, istat_q};
			`OSLOG_ADDR_IMASK: rd_mux = {28'h0, imask_q};
			`OSLOG_ADDR_FCODE: rd_mux = {16'h0, external_fault_code};
			`OSLOG_ADDR_SPEED: rd_mux = {16'h0, speed_ref};
			default: rd_mux = 32'h0;
		endcase
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0;
		end else if (ap_take && !hwrite) begin
			hrdata <= rd_mux;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sticky events: fault, alarm, parameter error, safe disable.
	wire [3:0] ev_now = {safe_disable, parameter_setting_error, alarm_active, fault_active};
	wire [3:0] w1c = wr_istat ? hwdata[3:0] : 4'h0;
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : ev_bit
			reg prev_q;
			reg stat_q;
			always @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					prev_q <= 1'b0;
					stat_q <= 1'b0;
				end else begin
					prev_q <= ev_now[g];
					// Hardware set wins over a software clear in the same cycle.
					if (ev_now[g] && !prev_q) begin
						stat_q <= 1'b1;
					end else if (w1c[g]) begin
						stat_q <= 1'b0;
					end
				end
			end
			assign istat_q[g] = stat_q;
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Run LED sequencing state.
	reg latch_remote_q;
	reg stop_remote_q;
	reg local_prev_q;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			local_prev_q <= 1'b1;
		end else begin
			local_prev_q <= local_q;
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			latch_remote_q <= 1'b0;
		end else if (local_prev_q && !local_q && term_cmd) begin
			latch_remote_q <= 1'b1;
		end else if (!term_cmd || local_q) begin
			latch_remote_q <= 1'b0;
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stop_remote_q <= 1'b0;
		end else if (stop_key && !local_q && drive_running) begin
			stop_remote_q <= 1'b1;
		end else if (!drive_running && !drive_decel) begin
			stop_remote_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Indicator decisions.
	// terminal command outside drive mode
	wire quick_term = term_cmd & ~drive_mode;
	wire quick_estop = estop_decel;
	wire quick_safe = safe_disable;
	wire quick_any = latch_remote_q | quick_term | quick_estop | quick_safe | stop_remote_q;
	wire flash_any = drive_decel | (updown_cmd & speed_ref_zero);

	always @* begin
		run_mode = `OSLOG_LED_OFF;
		if (quick_any) begin
			run_mode = `OSLOG_LED_QUICK;
		end else if (flash_any) begin
			run_mode = `OSLOG_LED_FLASH;
		end else if (drive_running) begin
			run_mode = `OSLOG_LED_ON;
		end
	end

	always @* begin
		alarm_mode = `OSLOG_LED_OFF;
		if (alarm_active || parameter_setting_error || tune_fault) begin
			alarm_mode = `OSLOG_LED_FLASH;
		end else if (fault_active || error_active) begin
			alarm_mode = `OSLOG_LED_ON;
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			alarm_indicator <= 1'b0;
			local_remote_indicator <= 1'b0;
			run_indicator <= 1'b0;
			drive_mode_tag <= 1'b0;
			prog_mode_tag <= 1'b0;
			show_fault <= 1'b0;
			display_data <= 16'h0;
			irq <= 1'b0;
		end else begin
			case (alarm_mode)
				`OSLOG_LED_ON: alarm_indicator <= 1'b1;
				`OSLOG_LED_FLASH: alarm_indicator <= slow_ph_q;
				default: alarm_indicator <= 1'b0;
			endcase
			local_remote_indicator <= local_q;
			case (run_mode)
				`OSLOG_LED_ON: run_indicator <= 1'b1;
				`OSLOG_LED_FLASH: run_indicator <= slow_ph_q;
				`OSLOG_LED_QUICK: run_indicator <= fast_ph_q;
				default: run_indicator <= 1'b0;
			endcase
			drive_mode_tag <= drive_mode & `OSLOG_TAG_DRV;
			prog_mode_tag <= ~drive_mode;
			show_fault <= fault_active;
			display_data <= fault_active ? external_fault_code : speed_ref;
			irq <= |(istat_q & imask_q);
		end
	end

endmodule // oslog_top

// >>> tb/oslog_panel.sv
// Operator at the panel: stop key and terminal command contact.
// Assumes requests from the bench.
`timescale 1ns/10ps
module oslog_panel (
	input wire logic stop_req,
	input wire logic term_req,
	output wire logic stop_key_pin,
	output wire logic term_cmd_pin
);
	// Odd delays keep the pins off the clock grid, as a hand would.
	assign #1.3 stop_key_pin = stop_req;
	assign #2.7 term_cmd_pin = term_req;
endmodule // oslog_panel

// >>> tb/oslog_sva.sv
// Checker for the status indication block.
// Assumes flash half-periods of 6 and 2 clocks.
`timescale 1ns/10ps
module oslog_sva #(
	parameter SLOW_CYC = 6,
	parameter FAST_CYC = 2
) (
	input wire hclk, hresetn, hreadyout, hresp, drive_decel, safe_disable, fault_active,
	input wire alarm_active, error_active, parameter_setting_error, tune_fault, drive_mode,
	input wire [15:0] speed_ref, external_fault_code, display_data,
	input wire alarm_indicator, run_indicator, drive_mode_tag, prog_mode_tag, show_fault
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	wire flash_src = alarm_active | parameter_setting_error | tune_fault;
	wire steady_src = fault_active | error_active;
	////////////////////////////////////////
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus not ready or okay");
	a_alarm_dark: assert property (!flash_src && !steady_src |=> !alarm_indicator)
		else $error("alarm lit while quiet");
	a_alarm_steady: assert property (steady_src && !flash_src |=> alarm_indicator)
		else $error("alarm not lit");
	a_alarm_flash: assert property (not ((parameter_setting_error && $stable(alarm_indicator)) [*8]))
		else $error("alarm not flashing");
	a_fault_disp: assert property (fault_active |=> show_fault && display_data == $past(external_fault_code))
		else $error("fault code not shown");
	a_speed_disp: assert property (!fault_active |=> !show_fault && display_data == $past(speed_ref))
		else $error("speed not shown");
	a_mode_tag: assert property (1'b1 |=> drive_mode_tag == $past(drive_mode) && prog_mode_tag != drive_mode_tag)
		else $error("mode tag wrong");
	a_run_quick: assert property (not ((safe_disable && $stable(run_indicator)) [*5]))
		else $error("run not flashing quickly");
	a_run_flash: assert property (not ((drive_decel && $stable(run_indicator)) [*8]))
		else $error("run not flashing");
endmodule // oslog_sva
bind oslog_top oslog_sva #(.SLOW_CYC(SLOW_CYC), .FAST_CYC(FAST_CYC)) oslog_sva_inst (.*);

// >>> tb/test_operator_status_led_logic.sv
// Bench for the status indication block.
// Assumes the panel model and the bound checker.
`timescale 1ns/10ps
module test_operator_status_led_logic;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, stop_req = 0, term_req = 0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, q;
	logic [11:0] st = 12'h800;
	logic [15:0] sp = 16'h0, efc = 16'h0;
	wire hreadyout, hresp, stop_key_pin, term_cmd_pin, alarm_indicator, local_remote_indicator;
	wire run_indicator, drive_mode_tag, prog_mode_tag, show_fault, irq;
	wire [15:0] display_data;
	wire [31:0] hrdata;
	integer err_count = 0, checks_done = 0, seed = 38, i;
	logic [11:0] cs [11] = '{12'h800, 12'h801, 12'h803, 12'h80c, 12'h813, 12'h821, 12'h900,
		12'h980, 12'ha00, 12'hc00, 12'h840};
	logic [3:0] ex [11] = '{4'h0, 4'h1, 4'h2, 4'h2, 4'h3, 4'h3, 4'h4, 4'h8, 4'h8, 4'h8, 4'h4};
	always #2 hclk = ~hclk;
	oslog_top #(.SLOW_CYC(6), .FAST_CYC(2)) oslog_top_inst (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .drive_running(st[0]), .drive_decel(st[1]), .updown_cmd(st[2]),
		.speed_ref_zero(st[3]), .estop_decel(st[4]), .safe_disable(st[5]),
		.fault_active(st[6]), .alarm_active(st[7]), .error_active(st[8]),
		.parameter_setting_error(st[9]), .tune_fault(st[10]), .drive_mode(st[11]),
		.speed_ref(sp), .external_fault_code(efc), .stop_key_pin(stop_key_pin),
		.term_cmd_pin(term_cmd_pin), .alarm_indicator(alarm_indicator),
		.local_remote_indicator(local_remote_indicator), .run_indicator(run_indicator),
		.drive_mode_tag(drive_mode_tag), .prog_mode_tag(prog_mode_tag),
		.show_fault(show_fault), .display_data(display_data), .irq(irq));
	oslog_panel oslog_panel_inst (.stop_req(stop_req), .term_req(term_req),
		.stop_key_pin(stop_key_pin), .term_cmd_pin(term_cmd_pin));
	////////////////////////////////////////
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {20'h0, a};
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		q = hrdata;
	endtask
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			err_count++;
			$display("MISMATCH %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic tick(input integer n);
		repeat (n) @(posedge hclk);
	endtask
	function automatic logic [15:0] disp(input logic f, input logic [15:0] c, s);
		return f ? c : s;
	endfunction
	task print_verdict;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		tick(20);
		hresetn <= 1'b1;
		tick(1);
		bus(1'b0, 12'h000, 32'h0);
		chk("ctrl", q, 32'h1);
		chk("lr_led", local_remote_indicator, 1'b1);
		bus(1'b0, 12'h00c, 32'h0);
		chk("imask", q, 32'h0);
		bus(1'b0, 12'h020, 32'h0);
		chk("unmapped", q, 32'h0);
		for (i = 0; i < 11; i++) begin
			st <= cs[i];
			tick(4);
			bus(1'b0, 12'h004, 32'h0);
			chk("modes", q[4:1], ex[i]);
		end
		st <= 12'h800;
		tick(2);
		bus(1'b0, 12'h008, 32'h0);
		chk("istat", q[3:0], 4'hf);
		chk("irq_mask", irq, 1'b0);
		bus(1'b1, 12'h00c, 32'h1);
		tick(2);
		chk("irq_on", irq, 1'b1);
		bus(1'b1, 12'h008, 32'hf);
		tick(2);
		chk("irq_off", irq, 1'b0);
		bus(1'b1, 12'h000, 32'h0);
		tick(2);
		chk("lr_led", local_remote_indicator, 1'b0);
		st <= 12'h801;
		stop_req <= 1'b1;
		tick(4);
		stop_req <= 1'b0;
		tick(4);
		bus(1'b0, 12'h004, 32'h0);
		chk("stop_key", q[2:1], 2'h3);
		st <= 12'h000;
		term_req <= 1'b1;
		tick(6);
		bus(1'b0, 12'h004, 32'h0);
		chk("term_cmd", q[2:1], 2'h3);
		chk("prog_tag", {drive_mode_tag, prog_mode_tag}, 2'h1);
		st <= 12'h800;
		bus(1'b1, 12'h000, 32'h1);
		bus(1'b1, 12'h000, 32'h0);
		tick(3);
		bus(1'b0, 12'h004, 32'h0);
		chk("latch", q[2:1], 2'h3);
		term_req <= 1'b0;
		for (i = 0; i < 8; i++) begin
			sp <= 16'($random(seed));
			efc <= 16'($random(seed));
			st <= {1'b1, 4'h0, i[0], 6'h0};
			tick(3);
			chk("display", display_data, disp(i[0], efc, sp));
			chk("tags", {show_fault, drive_mode_tag}, {i[0], 1'b1});
		end
		bus(1'b0, 12'h014, 32'h0);
		chk("speed_reg", q[15:0], sp);
		print_verdict();
	end
	initial begin
		#40000;
		err_count++;
		print_verdict();
	end
endmodule // test_operator_status_led_logic
